// ---- logic/dma_chan_ctrl.sv ----
// Purpose: Channel control, count and status for an endpoint DMA engine
// Assumes: AHB-Lite slave, one hclk domain, stream sources on hclk
// Notes:   Reads take one wait state; writes take none
//
// Notes on behaviour
// - Software reads back each channel's byte count
// - Software writes byte count to move
// - Channels chosen by zero-based index
// - Enable lets selected channel run its transfer
// - Disable one channel, others untouched
// - Per-channel interrupt enable allows interrupts
// - Clearing enable blocks only that channel
// - One status word, one bit per channel
// - Reading status word clears pending bits
// - Enabled channel's bit shows raised interrupt
// - Per-channel status, error flag while pending
// - Written status bits are cleared
// - Readable field gives number of channels
// - Channel count zero when controller absent
// - Multi-packet waits full packet; short raises event
//
// The AHB-Lite register port and the register offsets were left to the implementer.

`timescale 1ns/10ps

module dma_chan_ctrl
  import dma_chan_pkg::*;
#(
  parameter bit DMA_PRESENT = 1'b1
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  input  wire logic                        ep_valid,
  output logic                             ep_ready,
  input  wire logic [7:0]                  ep_data,
  input  wire logic [dma_chan_pkg::CH_W-1:0]   ep_chan,
  input  wire logic [dma_chan_pkg::NUM_CH-1:0] ep_pkt_full,
  input  wire logic                        ep_short_pkt,
  output logic                             short_pkt_event,
  output logic                             mem_valid,
  input  wire logic                        mem_ready,
  output logic [7:0]                       mem_data,
  output logic [dma_chan_pkg::CH_W-1:0]    mem_chan,
  input  wire logic                        mem_err,
  input  wire logic [dma_chan_pkg::CH_W-1:0]   mem_err_chan,
  output logic [dma_chan_pkg::NUM_CH-1:0]  chan_active
);
  import dma_chan_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ==========================================================
  // Bus front end
  bus_state_t        st_q, st_d;
  logic              wr_q, wr_d;
  logic [7:0]        addr_q, addr_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              req;
  logic              rd_req;
  logic              wr_now;
  logic              rd_now;

  assign req       = hsel && htrans[1] && hready;
  assign rd_req    = req && !hwrite;
  assign wr_now    = wr_q;
  assign rd_now    = (st_q == ST_RD_WAIT);
  assign hreadyout = (st_q != ST_RD_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // ==========================================================
  // Channel state
  logic [CH_W-1:0]    sel_q, sel_d;
  logic [NUM_CH-1:0]  en_q, en_d;
  logic [NUM_CH-1:0]  ie_q, ie_d;
  logic [NUM_CH-1:0]  mp_q, mp_d;
  logic [NUM_CH-1:0]  err_q, err_d;
  logic [NUM_CH-1:0]  ist_q, ist_d;
  logic [COUNT_W-1:0] cnt_q [NUM_CH];
  logic [COUNT_W-1:0] cnt_d [NUM_CH];
  logic               short_q, short_d;
  logic [NUM_CH-1:0]  go;
  logic               buf_in_ready;
  logic               accept;
  logic [NUM_CH-1:0]  done;

  // Channel runs only with count left and, in multi-packet mode,
  // only once a whole packet sits in its endpoint FIFO
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      go[i] = en_q[i] && (cnt_q[i] != RST_COUNT)
              && (!mp_q[i] || ep_pkt_full[i]);
    end
  end

  assign accept      = ep_valid && ep_ready;
  assign ep_ready    = buf_in_ready && go[ep_chan];
  assign chan_active = go;
  assign short_pkt_event = short_q;

  always_comb begin
    st_d    = st_q;
    wr_d    = 1'b0;
    addr_d  = addr_q;
    rdata_d = rdata_q;
    if (req) begin
      addr_d = haddr[7:0];
      wr_d   = hwrite;
    end
    case (st_q)
      ST_IDLE: begin
        if (rd_req) begin
          st_d = ST_RD_WAIT;
        end
      end
      ST_RD_WAIT: begin
        st_d    = ST_IDLE;
        rdata_d = RST_RDATA;
        if (hit(addr_q, OFF_INT_STATUS)) begin
          rdata_d[NUM_CH-1:0] = ist_q;
        end else if (hit(addr_q, OFF_NUM_CHAN)) begin
          rdata_d = DMA_PRESENT ? 32'(NUM_CH) : 32'h0;
        end else if (hit(addr_q, OFF_CHAN_SEL)) begin
          rdata_d[CH_W-1:0] = sel_q;
        end else if (hit(addr_q, OFF_CHAN_CTRL)) begin
          rdata_d[CTRL_EN_BIT] = en_q[sel_q];
          rdata_d[CTRL_IE_BIT] = ie_q[sel_q];
          rdata_d[CTRL_MP_BIT] = mp_q[sel_q];
        end else if (hit(addr_q, OFF_CHAN_COUNT)) begin
          rdata_d[COUNT_W-1:0] = cnt_q[sel_q];
        end else if (hit(addr_q, OFF_CHAN_STAT)) begin
          rdata_d[STAT_ERR_BIT] = err_q[sel_q];
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= ST_IDLE;
      wr_q    <= 1'b0;
      addr_q  <= 8'h00;
      rdata_q <= RST_RDATA;
    end else begin
      st_q    <= st_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Channel registers
  // Hardware sets win over software clears in the same cycle,
  // so no completion or error is lost to a racing clear
  always_comb begin
    sel_d   = sel_q;
    en_d    = en_q;
    ie_d    = ie_q;
    mp_d    = mp_q;
    err_d   = err_q;
    ist_d   = ist_q;
    short_d = ep_short_pkt;
    done    = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      cnt_d[i] = cnt_q[i];
    end
    if (wr_now && hit(addr_q, OFF_CHAN_SEL)) begin
      sel_d = hwdata[CH_W-1:0];
    end
    if (rd_now && hit(addr_q, OFF_INT_STATUS)) begin
      ist_d = '0;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (accept && (ep_chan == CH_W'(i))) begin
        cnt_d[i] = cnt_q[i] - COUNT_W'(1);
        if (cnt_q[i] == COUNT_W'(1)) begin
          done[i] = 1'b1;
          en_d[i] = 1'b0;
        end
      end
      if (wr_now && (sel_q == CH_W'(i))) begin
        if (hit(addr_q, OFF_CHAN_CTRL)) begin
          en_d[i] = hwdata[CTRL_EN_BIT];
          ie_d[i] = hwdata[CTRL_IE_BIT];
          mp_d[i] = hwdata[CTRL_MP_BIT];
        end
        if (hit(addr_q, OFF_CHAN_COUNT)) begin
          cnt_d[i] = hwdata[COUNT_W-1:0];
        end
        if (hit(addr_q, OFF_CHAN_STAT) && hwdata[STAT_ERR_BIT]) begin
          err_d[i] = 1'b0;
        end
      end
      if (mem_err && (mem_err_chan == CH_W'(i))) begin
        err_d[i] = 1'b1;
      end
      if (done[i] && ie_q[i]) begin
        ist_d[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q   <= RST_SEL;
      en_q    <= RST_FLAGS;
      ie_q    <= RST_FLAGS;
      mp_q    <= RST_FLAGS;
      err_q   <= RST_FLAGS;
      ist_q   <= RST_FLAGS;
      short_q <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        cnt_q[i] <= RST_COUNT;
      end
    end else begin
      sel_q   <= sel_d;
      en_q    <= en_d;
      ie_q    <= ie_d;
      mp_q    <= mp_d;
      err_q   <= err_d;
      ist_q   <= ist_d;
      short_q <= short_d;
      for (int i = 0; i < NUM_CH; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  // ==========================================================
  // Two-entry buffer toward memory
  // Holds two bytes so a memory stall never drops an accepted byte
  logic [7:0]      bdat_q [BUF_DEPTH];
  logic [7:0]      bdat_d [BUF_DEPTH];
  logic [CH_W-1:0] bch_q  [BUF_DEPTH];
  logic [CH_W-1:0] bch_d  [BUF_DEPTH];
  logic            wp_q, wp_d;
  logic            rp_q, rp_d;
  logic [1:0]      bcnt_q, bcnt_d;
  logic            pop;

  assign buf_in_ready = (bcnt_q != 2'(BUF_DEPTH));
  assign mem_valid    = (bcnt_q != 2'd0);
  assign mem_data     = bdat_q[rp_q];
  assign mem_chan     = bch_q[rp_q];
  assign pop          = mem_valid && mem_ready;

  always_comb begin
    wp_d   = wp_q;
    rp_d   = rp_q;
    bcnt_d = bcnt_q;
    for (int i = 0; i < BUF_DEPTH; i++) begin
      bdat_d[i] = bdat_q[i];
      bch_d[i]  = bch_q[i];
    end
    if (accept) begin
      bdat_d[wp_q] = ep_data;
      bch_d[wp_q]  = ep_chan;
      wp_d         = !wp_q;
    end
    if (pop) begin
      rp_d = !rp_q;
    end
    case ({accept, pop})
      2'b10:   bcnt_d = bcnt_q + 2'd1;
      2'b01:   bcnt_d = bcnt_q - 2'd1;
      default: bcnt_d = bcnt_q;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q   <= 1'b0;
      rp_q   <= 1'b0;
      bcnt_q <= 2'd0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        bdat_q[i] <= 8'h00;
        bch_q[i]  <= RST_SEL;
      end
    end else begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      bcnt_q <= bcnt_d;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        bdat_q[i] <= bdat_d[i];
        bch_q[i]  <= bch_d[i];
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_rd_taken;
    rd_req && hreadyout;
  endsequence

  sequence seq_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_read_wait_one: assert property (
    seq_rd_taken |=> seq_one_wait)
    else $error("read did not take exactly one wait state");

  chk_num_chan_read: assert property (
    (rd_req && hreadyout && (haddr[7:0] == OFF_NUM_CHAN))
    |-> ##2 (hrdata == (DMA_PRESENT ? 32'(NUM_CH) : 32'h0)))
    else $error("channel count read wrong");

  chk_ist_read_clr: assert property (
    (rd_now && hit(addr_q, OFF_INT_STATUS) && (done == '0))
    |=> (ist_q == '0))
    else $error("status word not cleared by read");

  chk_done_sets_ist: assert property (
    (accept && (cnt_q[ep_chan] == COUNT_W'(1)) && ie_q[ep_chan])
    |=> ist_q[$past(ep_chan)])
    else $error("completion did not set status bit");

  chk_ie_off_quiet: assert property (
    (done != '0) && ((done & ie_q) == '0)
    |=> ((ist_q & ~$past(ist_q)) == '0))
    else $error("masked channel raised status");

  chk_done_disables: assert property (
    (accept && (cnt_q[ep_chan] == COUNT_W'(1))
     && !(wr_now && hit(addr_q, OFF_CHAN_CTRL)))
    |=> !en_q[$past(ep_chan)])
    else $error("finished channel still enabled");

  chk_count_dec: assert property (
    (accept && (cnt_q[ep_chan] > COUNT_W'(1))
     && !(wr_now && hit(addr_q, OFF_CHAN_COUNT)))
    |=> (cnt_q[$past(ep_chan)] == $past(cnt_q[ep_chan]) - COUNT_W'(1)))
    else $error("count did not drop by one");

  chk_mp_waits: assert property (
    (mp_q[ep_chan] && !ep_pkt_full[ep_chan]) |-> !ep_ready)
    else $error("multi-packet channel ran before full packet");

  chk_err_sets: assert property (
    mem_err |=> err_q[$past(mem_err_chan)])
    else $error("error flag not set");

  chk_buf_full: assert property (
    (bcnt_q == 2'd2) && !mem_ready |=> (bcnt_q == 2'd2) && !ep_ready)
    else $error("buffer overfilled");

endmodule // dma_chan_ctrl

// ---- logic/dma_chan_pkg.sv ----
// Purpose: Shared constants for the endpoint DMA channel block
// Assumes: AHB-Lite register access, 32-bit data, one clock
// Notes:   All offsets are byte addresses of aligned words

package dma_chan_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_CH   = 8;
  localparam int CH_W     = 3;
  localparam int COUNT_W  = 16;
  localparam int BUF_DEPTH = 2;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_INT_STATUS = 8'h00;
  localparam logic [7:0] OFF_NUM_CHAN   = 8'h04;
  localparam logic [7:0] OFF_CHAN_SEL   = 8'h08;
  localparam logic [7:0] OFF_CHAN_CTRL  = 8'h0c;
  localparam logic [7:0] OFF_CHAN_COUNT = 8'h10;
  localparam logic [7:0] OFF_CHAN_STAT  = 8'h14;

  // ==========================================================
  // Field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_IE_BIT  = 1;
  localparam int CTRL_MP_BIT  = 2;
  localparam int STAT_ERR_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [NUM_CH-1:0]  RST_FLAGS = 8'h00;
  localparam logic [COUNT_W-1:0] RST_COUNT = 16'h0000;
  localparam logic [CH_W-1:0]    RST_SEL   = 3'h0;
  localparam logic [31:0]        RST_RDATA = 32'h0000_0000;

  // ==========================================================
  // Bus read sequencing
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RD_WAIT = 2'b01
  } bus_state_t;

endpackage

// ---- dv/dma_mem_model.sv ----
// Purpose: Memory-side sink for the DMA byte stream
// Assumes: One hclk domain, byte-wide stream
// Notes:   Stall holds mem_ready low so the buffer backs up

`timescale 1ns/10ps

module dma_mem_model
  import dma_chan_pkg::*;
(
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          stall,
  input  wire logic                          mem_valid,
  input  wire logic [7:0]                    mem_data,
  input  wire logic [dma_chan_pkg::CH_W-1:0] mem_chan,
  output logic                               mem_ready,
  output logic [7:0]                         rx_count
);
  logic [7:0]      rx_data [0:15];
  logic [CH_W-1:0] rx_chan [0:15];

  // ============================================================
  // Sink
  // Never ready in reset, so nothing is taken before release
  assign mem_ready = hresetn && !stall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_count <= 8'h00;
    end else if (mem_valid && mem_ready) begin
      rx_data[rx_count[3:0]] <= mem_data;
      rx_chan[rx_count[3:0]] <= mem_chan;
      rx_count <= rx_count + 8'h01;
    end
  end
endmodule // dma_mem_model

// ---- dv/usb_integrated_dma_channels_tb_top.sv ----
// Purpose: Self-checking bench for the DMA channel block
// Assumes: Two AHB-Lite slaves sharing hsel, hready of both tied to dut's hreadyout
// Notes:   Table of register cases first, then hand tests

`timescale 1ns/10ps

module usb_integrated_dma_channels_tb_top;
  import dma_chan_pkg::*;

  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
  } row_t;

  logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
  logic              hwrite = 1'b0, ep_valid = 1'b0, stall = 1'b0;
  logic              ep_short_pkt = 1'b0, mem_err = 1'b0;
  logic [1:0]        htrans = 2'b00;
  logic [31:0]       haddr = 32'h0, hwdata = 32'h0;
  logic [7:0]        ep_data = 8'h00;
  logic [CH_W-1:0]   ep_chan = 3'h0, mem_err_chan = 3'h0;
  logic [NUM_CH-1:0] ep_pkt_full = 8'h00;
  logic              hreadyout, hresp, ep_ready, short_pkt_event;
  logic              mem_valid, mem_ready;
  logic [31:0]       hrdata, hrdata_abs;
  logic [7:0]        mem_data, rx_count;
  logic [CH_W-1:0]   mem_chan;
  logic [NUM_CH-1:0] chan_active;
  int                fail_count = 0, samples_checked = 0, cyc = 0;

  // Reads expect d; unmapped offset 0x20 must read zero
  row_t rows [18] = '{
    '{1'b0, OFF_INT_STATUS, 32'h0}, '{1'b0, OFF_NUM_CHAN, 32'h8},
    '{1'b0, OFF_CHAN_SEL, 32'h0},   '{1'b0, OFF_CHAN_CTRL, 32'h0},
    '{1'b0, OFF_CHAN_COUNT, 32'h0}, '{1'b0, OFF_CHAN_STAT, 32'h0},
    '{1'b1, OFF_CHAN_SEL, 32'h1},   '{1'b1, OFF_CHAN_COUNT, 32'h200},
    '{1'b1, OFF_CHAN_SEL, 32'h6},   '{1'b1, OFF_CHAN_COUNT, 32'hffff},
    '{1'b0, OFF_CHAN_COUNT, 32'hffff}, '{1'b1, OFF_CHAN_SEL, 32'h1},
    '{1'b0, OFF_CHAN_COUNT, 32'h200}, '{1'b1, OFF_CHAN_CTRL, 32'h6},
    '{1'b0, OFF_CHAN_CTRL, 32'h6},  '{1'b1, 8'h20, 32'h5a},
    '{1'b0, 8'h20, 32'h0},          '{1'b0, OFF_CHAN_SEL, 32'h1}};

  always #12.5 hclk = ~hclk;

  dma_chan_ctrl dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ep_valid(ep_valid), .ep_ready(ep_ready),
    .ep_data(ep_data), .ep_chan(ep_chan), .ep_pkt_full(ep_pkt_full),
    .ep_short_pkt(ep_short_pkt), .short_pkt_event(short_pkt_event),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_data(mem_data),
    .mem_chan(mem_chan), .mem_err(mem_err),
    .mem_err_chan(mem_err_chan), .chan_active(chan_active));

  // Copy built without the controller; only its channel count differs
  dma_chan_ctrl #(.DMA_PRESENT(1'b0)) dut_absent (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(), .hresp(),
    .hrdata(hrdata_abs), .ep_valid(ep_valid), .ep_ready(),
    .ep_data(ep_data), .ep_chan(ep_chan), .ep_pkt_full(ep_pkt_full),
    .ep_short_pkt(ep_short_pkt), .short_pkt_event(),
    .mem_valid(), .mem_ready(mem_ready), .mem_data(),
    .mem_chan(), .mem_err(mem_err),
    .mem_err_chan(mem_err_chan), .chan_active());

  dma_mem_model mem (
    .hclk(hclk), .hresetn(hresetn), .stall(stall),
    .mem_valid(mem_valid), .mem_data(mem_data), .mem_chan(mem_chan),
    .mem_ready(mem_ready), .rx_count(rx_count));

  // ============================================================
  // Tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Holds each phase until hready is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(n, e, x);
  endtask

  // Bytes a0, a1, ... each held until taken
  task automatic send(input logic [CH_W-1:0] c, input int n);
    for (int i = 0; i < n; i++) begin
      ep_valid <= 1'b1;
      ep_chan <= c;
      ep_data <= 8'ha0 + 8'(i);
      @(posedge hclk);
      while (ep_ready !== 1'b1) @(posedge hclk);
    end
    ep_valid <= 1'b0;
  endtask

  // ============================================================
  // Timeout
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end

  // ============================================================
  // Sequence
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rdc("table", rows[i].a, rows[i].d);
      if (!rows[i].w && (rows[i].a == OFF_NUM_CHAN))
        check("absent count", 32'h0, hrdata_abs);
    end
    $display("register table done");
    // Memory stalls so the two-entry buffer fills and refuses
    stall <= 1'b1;
    wr(OFF_CHAN_SEL, 32'h2);
    wr(OFF_CHAN_COUNT, 32'h3);
    wr(OFF_CHAN_CTRL, 32'h3);
    fork
      send(3'h2, 3);
      begin
        repeat (8) @(posedge hclk);
        check("ep_ready full", 32'h0, 32'(ep_ready));
        check("mem_data head", 32'ha0, 32'(mem_data));
        stall <= 1'b0;
      end
    join
    repeat (4) @(posedge hclk);
    check("rx_count", 32'h3, 32'(rx_count));
    check("rx last", 32'ha2, 32'(mem.rx_data[2]));
    check("rx chan", 32'h2, 32'(mem.rx_chan[0]));
    check("mem idle", 32'h0, 32'(mem_valid));
    rdc("count done", OFF_CHAN_COUNT, 32'h0);
    check("hresp", 32'h0, 32'(hresp));
    rdc("ctrl done", OFF_CHAN_CTRL, 32'h2);
    rdc("int set", OFF_INT_STATUS, 32'h4);
    rdc("int clr", OFF_INT_STATUS, 32'h0);
    $display("stalled transfer done");
    // Channel 0 interrupts, 7 does not, 3 is disabled
    wr(OFF_CHAN_SEL, 32'h0);
    wr(OFF_CHAN_COUNT, 32'h1);
    wr(OFF_CHAN_CTRL, 32'h3);
    wr(OFF_CHAN_SEL, 32'h7);
    wr(OFF_CHAN_COUNT, 32'h1);
    wr(OFF_CHAN_CTRL, 32'h1);
    wr(OFF_CHAN_SEL, 32'h3);
    wr(OFF_CHAN_COUNT, 32'h2);
    wr(OFF_CHAN_CTRL, 32'h1);
    wr(OFF_CHAN_CTRL, 32'h0);
    @(posedge hclk);
    check("active", 32'h81, 32'(chan_active));
    send(3'h0, 1);
    @(posedge hclk);
    send(3'h7, 1);
    rdc("int mask", OFF_INT_STATUS, 32'h1);
    $display("enable and mask done");
    // Multi-packet channel waits for a full packet
    wr(OFF_CHAN_SEL, 32'h5);
    wr(OFF_CHAN_COUNT, 32'h2);
    wr(OFF_CHAN_CTRL, 32'h5);
    ep_short_pkt <= 1'b1;
    @(posedge hclk);
    ep_short_pkt <= 1'b0;
    @(posedge hclk);
    check("short event", 32'h1, 32'(short_pkt_event));
    check("mp waits", 32'h0, 32'(chan_active));
    ep_pkt_full <= 8'h20;
    @(posedge hclk);
    check("mp runs", 32'h20, 32'(chan_active));
    check("short over", 32'h0, 32'(short_pkt_event));
    $display("multi-packet done");
    // Error flag on channel 4, cleared by writing back what was read
    @(posedge hclk);
    mem_err <= 1'b1;
    mem_err_chan <= 3'h4;
    @(posedge hclk);
    mem_err <= 1'b0;
    wr(OFF_CHAN_SEL, 32'h4);
    rdc("err set", OFF_CHAN_STAT, 32'h1);
    wr(OFF_CHAN_STAT, 32'h1);
    rdc("err clr", OFF_CHAN_STAT, 32'h0);
    $display("error status done");
    // Mid-run reset returns selection, counts and enables to zero
    hresetn <= 1'b0;
    @(posedge hclk);
    check("rst active", 32'h0, 32'(chan_active));
    hresetn <= 1'b1;
    rdc("rst sel", OFF_CHAN_SEL, 32'h0);
    wr(OFF_CHAN_SEL, 32'h5);
    rdc("rst count", OFF_CHAN_COUNT, 32'h0);
    $display("reset done");
    conclude();
  end
endmodule // usb_integrated_dma_channels_tb_top
